// [rtl/store_pkg.sv]
// constants, types and decode helpers shared by the parameter store block
package store_pkg;

	// ------------------------------------------------------------------
	// object indices and subindices (byte address = {index, sub} * 4)
	// ------------------------------------------------------------------
	localparam logic [15:0] OBJ_STORE   = 16'h1010;
	localparam logic [15:0] OBJ_RESTORE = 16'h1011;
	localparam logic [15:0] OBJ_MARKER  = 16'h1020;
	localparam logic [15:0] OBJ_REBOOT  = 16'h2800;
	localparam logic [15:0] OBJ_PARAM   = 16'h3000;
	localparam logic [15:0] OBJ_IRQ     = 16'h3100;
	localparam logic [7:0]  SUB_BOOT    = 8'h01;
	localparam logic [7:0]  SUB_DATE    = 8'h01;
	localparam logic [7:0]  SUB_TIME    = 8'h02;
	localparam logic [7:0]  SUB_STATUS  = 8'h00;
	localparam logic [7:0]  SUB_MASK    = 8'h01;

	// ------------------------------------------------------------------
	// signatures, values and category masks
	// ------------------------------------------------------------------
	localparam logic [31:0] SIG_SAVE      = 32'h65766173;
	localparam logic [31:0] SIG_LOAD      = 32'h64616f6c;
	localparam logic [31:0] SIG_BOOT      = 32'h746f6f62;
	localparam logic [31:0] SAVE_DONE_VAL = 32'h00000001;
	localparam logic [31:0] MARKER_CLEAR  = 32'h00000000;
	localparam logic [31:0] FACTORY_VALUE = 32'h00000000;
	localparam logic [31:0] REG_RESET     = 32'h00000000;
	localparam int          CAT_COUNT     = 6;
	// bit order: comm, application, user, movement, tuning, ethernet
	localparam logic [5:0]  MASK_SAVE_ALL    = 6'b011111;
	localparam logic [5:0]  MASK_DISCARD_ALL = 6'b001111;
	localparam logic [2:0]  SLOT_ALL  = 3'd6;
	localparam logic [2:0]  SLOT_NONE = 3'd7;
	localparam int IRQ_SAVE    = 0;
	localparam int IRQ_DISCARD = 1;
	localparam int IRQ_REBOOT  = 2;
	localparam int IRQ_W       = 3;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam longint CLK_HZ       = 20000000;
	localparam longint SAVE_TIME_MS = 2000;
	localparam int     SAVE_CYCLES  = int'(SAVE_TIME_MS * CLK_HZ / 1000);

	typedef struct packed {
		logic [31:0] date;
		logic [31:0] tod;
	} marker_s;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SAVE   = 2'b01,
		ST_REBOOT = 2'b10
	} ctrl_e;

	// subindex to slot: 0..5 one category, 6 all, 7 not a category
	function automatic logic [2:0] sub_slot(input logic [7:0] sub);
		case (sub)
			8'h01:   sub_slot = SLOT_ALL;
			8'h02:   sub_slot = 3'd0;
			8'h03:   sub_slot = 3'd1;
			8'h04:   sub_slot = 3'd2;
			8'h05:   sub_slot = 3'd3;
			8'h06:   sub_slot = 3'd4;
			8'h0c:   sub_slot = 3'd5;
			default: sub_slot = SLOT_NONE;
		endcase
	endfunction

	function automatic logic [5:0] slot_mask(input logic [2:0] slot,
		input logic restore);
		if (slot == SLOT_ALL)
			slot_mask = restore ? MASK_DISCARD_ALL : MASK_SAVE_ALL;
		else
			slot_mask = 6'(6'h01 << slot);
	endfunction

endpackage

// [rtl/save_timer.sv]
// busy timer that models the duration of a non-volatile write
`timescale 1ns/100ps
`default_nettype none
module save_timer
	import store_pkg::*;
#(
	parameter int CYCLES = SAVE_CYCLES
)(
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic start,
	output logic      busy,
	output logic      done
);
	logic [31:0] count_reg;

	// count down from start; done is one pulse in the last busy cycle
	always_ff @(posedge clk)
	begin
		if (!nrst)
			count_reg <= 32'h0;
		else if (start)
			count_reg <= 32'(CYCLES);
		else if (count_reg != 32'h0)
			count_reg <= count_reg - 32'h1;
	end

	assign busy = (count_reg != 32'h0);
	assign done = (count_reg == 32'h1);
endmodule // save_timer
`default_nettype wire

// [rtl/param_nv.sv]
// non-volatile image of the savable parameters and the marker
`timescale 1ns/100ps
`default_nettype none
module param_nv
	import store_pkg::*;
(
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire logic                        commit,
	input  wire logic [CAT_COUNT-1:0]        commit_mask,
	input  wire logic [CAT_COUNT-1:0][31:0]  commit_data,
	input  wire logic                        commit_marker,
	input  wire marker_s                     marker_in,
	input  wire logic                        discard,
	input  wire logic [CAT_COUNT-1:0]        discard_mask,
	input  wire logic                        reboot,
	output logic      [CAT_COUNT-1:0][31:0]  view_param,
	output marker_s                          view_marker,
	output logic      [CAT_COUNT-1:0]        discarded
);
	logic [31:0] nv_mem [0:CAT_COUNT-1];
	marker_s     marker_mem;

	// per category: a fresh save clears the discard mark, a reboot
	// turns a discarded image into factory values
	genvar i;
	generate
		for (i = 0; i < CAT_COUNT; i++)
		begin : g_cat
			always_ff @(posedge clk)
			begin
				if (!nrst)
				begin
					nv_mem[i]    <= FACTORY_VALUE;
					discarded[i] <= 1'b0;
				end
				else if (commit && commit_mask[i])
				begin
					nv_mem[i]    <= commit_data[i];
					discarded[i] <= 1'b0;
				end
				else if (discard && discard_mask[i])
					discarded[i] <= 1'b1;
				else if (reboot && discarded[i])
				begin
					nv_mem[i]    <= FACTORY_VALUE;
					discarded[i] <= 1'b0;
				end
			end
			assign view_param[i] = discarded[i] ? FACTORY_VALUE : nv_mem[i];
		end
	endgenerate

	// marker travels only with a save through store subindex 01
	always_ff @(posedge clk)
	begin
		if (!nrst)
			marker_mem <= '0;
		else if (commit && commit_marker)
			marker_mem <= marker_in;
	end

	assign view_marker = marker_mem;
endmodule // param_nv
`default_nettype wire

// [rtl/param_store.sv]
// apb reachable parameter save, discard, reboot and marker logic
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - save signature in a store subindex starts saving that category
// - on save completion the commanded store subindex reads back 1
// - store subindex 01 all but ethernet; 02-06 and 0c single categories
// - load signature in a restore subindex marks that stored data discarded
// - restore subindex 01 spares tuning and ethernet
// - discard leaves working values alone until the next restart
// - boot signature in reboot subindex 01 restarts the device
// - marker date and time are saved along with save-all
// - savable writes clear the marker, except save-all and marker writes
module param_store
	import store_pkg::*;
#(
	parameter int ADDR_W      = 26,
	parameter int SAVE_CYC    = SAVE_CYCLES
)(
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	output logic                   save_busy,
	output logic                   irq
);
	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [31:0]                store_reg   [0:6];
	logic [31:0]                restore_reg [0:6];
	logic [31:0]                reboot_reg;
	logic [CAT_COUNT-1:0][31:0] param_reg;
	marker_s                    marker_reg;
	logic [IRQ_W-1:0]           status_reg;
	logic [IRQ_W-1:0]           status_next;
	logic [IRQ_W-1:0]           mask_reg;
	ctrl_e                      state_reg;
	logic [2:0]                 cmd_slot_reg;
	logic [CAT_COUNT-1:0]       cmd_mask_reg;
	logic [15:0]          obj;
	logic [7:0]           sub;
	logic [2:0]           slot;
	logic                 hit_store;
	logic                 hit_restore;
	logic                 hit_marker;
	logic                 hit_reboot;
	logic                 hit_param;
	logic                 hit_irq;
	logic                 is_cmd;
	logic                 mapped;
	logic                 bad;
	logic                 wr;
	logic                 save_start;
	logic                 discard_go;
	logic                 reboot_go;
	logic                 timer_done;
	logic [CAT_COUNT-1:0] discard_mask;
	logic [CAT_COUNT-1:0][31:0] nv_param;
	marker_s              nv_marker;
	logic [31:0]          rd_value;

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	// address bits above the register word carry {object, subindex}
	assign obj  = paddr[25:10];
	assign sub  = paddr[9:2];
	assign slot = sub_slot(sub);

	assign hit_store   = (obj == OBJ_STORE) && (slot != SLOT_NONE);
	assign hit_restore = (obj == OBJ_RESTORE) && (slot != SLOT_NONE);
	assign hit_marker  = (obj == OBJ_MARKER) &&
		((sub == SUB_DATE) || (sub == SUB_TIME));
	assign hit_reboot  = (obj == OBJ_REBOOT) && (sub == SUB_BOOT);
	assign hit_param   = (obj == OBJ_PARAM) && (sub < 8'(CAT_COUNT));
	assign hit_irq     = (obj == OBJ_IRQ) &&
		((sub == SUB_STATUS) || (sub == SUB_MASK));
	assign mapped = hit_store | hit_restore | hit_marker | hit_reboot |
		hit_param | hit_irq;
	assign is_cmd = hit_store | hit_restore | hit_reboot;

	// commands while busy are refused whole; parameter and marker writes during a save still land in it
	assign bad    = !mapped || (pwrite && is_cmd && (state_reg != ST_IDLE));
	assign wr     = psel && penable && pwrite && !bad;

	assign pready  = 1'b1;
	assign pslverr = psel && penable && bad;

	// only the defined signatures turn a write into a command
	assign save_start = wr && hit_store && (pwdata == SIG_SAVE);
	assign discard_go = wr && hit_restore && (pwdata == SIG_LOAD);
	assign reboot_go  = wr && hit_reboot && (pwdata == SIG_BOOT);
	assign discard_mask = slot_mask(slot, 1'b1);
	assign save_busy  = (state_reg == ST_SAVE);

	// ------------------------------------------------------------------
	// save sequencer and store subindices
	// ------------------------------------------------------------------
	// the mask is latched at start so that the commit sees the command
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_reg    <= ST_IDLE;
			cmd_slot_reg <= SLOT_NONE;
			cmd_mask_reg <= '0;
		end
		else
		begin
			unique case (state_reg)
				ST_IDLE:
				begin
					if (save_start)
					begin
						state_reg    <= ST_SAVE;
						cmd_slot_reg <= slot;
						cmd_mask_reg <= slot_mask(slot, 1'b0);
					end
					else if (reboot_go)
						state_reg <= ST_REBOOT;
				end
				ST_SAVE:
				begin
					if (timer_done)
						state_reg <= ST_IDLE;
				end
				ST_REBOOT:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	genvar k;
	generate
		for (k = 0; k < 7; k++)
		begin : g_store
			// store value reads back as written until the save ends
			always_ff @(posedge clk)
			begin
				if (!nrst)
					store_reg[k] <= REG_RESET;
				else if (timer_done && (cmd_slot_reg == 3'(k)))
					store_reg[k] <= SAVE_DONE_VAL;
				else if (wr && hit_store && (slot == 3'(k)))
					store_reg[k] <= pwdata;
			end

			always_ff @(posedge clk)
			begin
				if (!nrst)
					restore_reg[k] <= REG_RESET;
				else if (wr && hit_restore && (slot == 3'(k)))
					restore_reg[k] <= pwdata;
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (!nrst)
			reboot_reg <= REG_RESET;
		else if (state_reg == ST_REBOOT)
			reboot_reg <= REG_RESET;  // a restart clears the command
		else if (wr && hit_reboot)
			reboot_reg <= pwdata;
	end

	save_timer #(
		.CYCLES (SAVE_CYC)
	) u_timer (
		.clk   (clk),
		.nrst  (nrst),
		.start (save_start),
		.busy  (),
		.done  (timer_done)
	);

	param_nv u_nv (
		.clk           (clk),
		.nrst          (nrst),
		.commit        (timer_done),
		.commit_mask   (cmd_mask_reg),
		.commit_data   (param_reg),
		.commit_marker (cmd_slot_reg == SLOT_ALL),
		.marker_in     (marker_reg),
		.discard       (discard_go),
		.discard_mask  (discard_mask),
		.reboot        (state_reg == ST_REBOOT),
		.view_param    (nv_param),
		.view_marker   (nv_marker),
		.discarded     ()
	);

	// ------------------------------------------------------------------
	// working parameters and marker
	// ------------------------------------------------------------------
	// a discard touches only the image; values change on restart only
	always_ff @(posedge clk)
	begin
		if (!nrst)
			param_reg <= '0;
		else if (state_reg == ST_REBOOT)
			param_reg <= nv_param;
		else if (wr && hit_param)
			param_reg[sub[2:0]] <= pwdata;
	end

	// marker clears on any write to a single-category store subindex and on parameter writes
	always_ff @(posedge clk)
	begin
		if (!nrst)
			marker_reg <= '0;
		else if (state_reg == ST_REBOOT)
			marker_reg <= nv_marker;
		else if (wr && hit_marker && (sub == SUB_DATE))
			marker_reg.date <= pwdata;
		else if (wr && hit_marker)
			marker_reg.tod <= pwdata;
		else if (wr && (hit_param || (hit_store && slot != SLOT_ALL)))
			marker_reg <= {MARKER_CLEAR, MARKER_CLEAR};
	end

	// ------------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------------
	// a new event in the clearing cycle survives the write of one
	always_comb
	begin
		status_next = status_reg;
		if (wr && hit_irq && (sub == SUB_STATUS))
			status_next = status_next & ~pwdata[IRQ_W-1:0];
		status_next[IRQ_SAVE]    = status_next[IRQ_SAVE] | timer_done;
		status_next[IRQ_DISCARD] = status_next[IRQ_DISCARD] | discard_go;
		status_next[IRQ_REBOOT]  = status_next[IRQ_REBOOT] |
			(state_reg == ST_REBOOT);
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			status_reg <= '0;
		else
			status_reg <= status_next;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			mask_reg <= '0;
		else if (wr && hit_irq && (sub == SUB_MASK))
			mask_reg <= pwdata[IRQ_W-1:0];
	end

	assign irq = |(status_reg & mask_reg);

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	always_comb
	begin
		rd_value = 32'h0;
		if (hit_store)
			rd_value = store_reg[slot];
		else if (hit_restore)
			rd_value = restore_reg[slot];
		else if (hit_marker)
			rd_value = (sub == SUB_DATE) ? marker_reg.date : marker_reg.tod;
		else if (hit_reboot)
			rd_value = reboot_reg;
		else if (hit_param)
			rd_value = param_reg[sub[2:0]];
		else if (hit_irq)
			rd_value = (sub == SUB_STATUS) ? 32'(status_reg) : 32'(mask_reg);
	end

	// captured in the setup cycle so prdata comes from a flop
	always_ff @(posedge clk)
	begin
		if (!nrst)
			prdata <= 32'h0;
		else if (psel && !penable)
			prdata <= rd_value;
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	property p_save_starts;
		@(posedge clk) disable iff (!nrst)
		(state_reg == ST_IDLE && wr && hit_store && pwdata == SIG_SAVE)
		|=> (state_reg == ST_SAVE) && save_busy;
	endproperty
	a_save_starts: assert property (p_save_starts)
		else $error("save signature did not start a save");
	property p_done_one;
		@(posedge clk) disable iff (!nrst)
		timer_done |=> store_reg[$past(cmd_slot_reg)] == SAVE_DONE_VAL
			&& state_reg == ST_IDLE;
	endproperty
	a_done_one: assert property (p_done_one)
		else $error("store subindex not set to one after save");
	property p_save_all_mask;
		@(posedge clk) disable iff (!nrst)
		(save_start && state_reg == ST_IDLE && slot == SLOT_ALL)
		|=> cmd_mask_reg == MASK_SAVE_ALL;
	endproperty
	a_save_all_mask: assert property (p_save_all_mask)
		else $error("save all selected wrong categories");
	property p_discard_go;
		@(posedge clk) disable iff (!nrst)
		(wr && hit_restore && pwdata == SIG_LOAD) |-> (discard_mask != '0)
			##1 status_reg[IRQ_DISCARD];
	endproperty
	a_discard_go: assert property (p_discard_go)
		else $error("load signature did not discard");
	property p_discard_all_mask;
		@(posedge clk) disable iff (!nrst)
		(discard_go && slot == SLOT_ALL) |-> (&discard_mask[3:0])
			&& !discard_mask[4] && !discard_mask[5];
	endproperty
	a_discard_all_mask: assert property (p_discard_all_mask)
		else $error("discard all touched tuning or ethernet");
	property p_discard_keeps;
		@(posedge clk) disable iff (!nrst)
		(discard_go && state_reg == ST_IDLE) |=> param_reg == $past(param_reg);
	endproperty
	a_discard_keeps: assert property (p_discard_keeps)
		else $error("discard changed working parameters");
	property p_reboot;
		@(posedge clk) disable iff (!nrst)
		(reboot_go && state_reg == ST_IDLE && !save_start)
		|=> state_reg == ST_REBOOT ##1 state_reg == ST_IDLE;
	endproperty
	a_reboot: assert property (p_reboot)
		else $error("boot signature did not restart");
	property p_marker_saved;
		@(posedge clk) disable iff (!nrst)
		(timer_done && cmd_slot_reg == SLOT_ALL) |=> nv_marker == $past(marker_reg);
	endproperty
	a_marker_saved: assert property (p_marker_saved)
		else $error("marker not saved with save all");
	property p_marker_clear;
		@(posedge clk) disable iff (!nrst)
		(wr && hit_param && state_reg != ST_REBOOT) |=> marker_reg == '0;
	endproperty
	a_marker_clear: assert property (p_marker_clear)
		else $error("parameter write left the marker set");
	property p_no_command;
		@(posedge clk) disable iff (!nrst)
		(state_reg == ST_IDLE && wr && hit_store && pwdata != SIG_SAVE)
		|=> state_reg != ST_SAVE;
	endproperty
	a_no_command: assert property (p_no_command)
		else $error("non signature value started a save");
endmodule // param_store
`default_nettype wire

// [bench/apb_master.sv]
// apb master model standing in for the fieldbus master or tool
`timescale 1ns/100ps
`default_nettype none
module apb_master
(
	input  wire logic        clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [25:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	// ----------------------------------------------------------------
	// idle bus
	// ----------------------------------------------------------------
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end

	// ----------------------------------------------------------------
	// one transfer: setup, access until pready, then release
	// ----------------------------------------------------------------
	// released address and data show the inverse so stale values never
	// look like a fresh request
	task automatic xfer(input logic w, input logic [25:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no cycle limit here: only the bench timeout ends a hang
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule // apb_master
`default_nettype wire

// [bench/param_store_tb_top.sv]
// self-checking testbench of the parameter store block
`timescale 1ns/100ps
`default_nettype none
module param_store_tb_top;
	import store_pkg::*;
	logic        clk;
	logic        nrst;
	logic        psel, penable, pwrite, pready, pslverr, save_busy, irq;
	logic [25:0] paddr;
	logic [31:0] pwdata, prdata;
	int          fail_count, total_checks, cycles;
	logic [31:0] dv, tv;

	param_store #(.ADDR_W(26), .SAVE_CYC(8)) u_param_store (.clk(clk),
		.nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .save_busy(save_busy), .irq(irq));
	apb_master u_apb_master (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr));

	// ----------------------------------------------------------------
	// clock, reset and timeout
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ceiling well above the few hundred cycles the tests need
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [25:0] oa(logic [15:0] i, logic [7:0] s);
		return {i, s, 2'b00};
	endfunction
	function automatic logic [31:0] pv(int i);
		return 32'ha5000000 | 32'(i + 1);
	endfunction
	task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(logic [25:0] a, logic [31:0] d, logic ee);
		logic [31:0] q;
		logic e;
		u_apb_master.xfer(1'b1, a, d, q, e);
		check("pslverr", {31'h0, e}, {31'h0, ee});
	endtask
	task automatic rd(logic [25:0] a, logic [31:0] exp, string n);
		logic [31:0] q;
		logic e;
		u_apb_master.xfer(1'b0, a, 32'h0, q, e);
		check("pslverr", {31'h0, e}, 32'h0);
		check(n, q, exp);
	endtask
	// sampled at the falling edge, after the launching edge has settled
	task automatic pin(string n, logic exp);
		logic v;
		@(negedge clk);
		v = (n == "irq") ? irq : (n == "pready") ? pready : save_busy;
		check(n, {31'h0, v}, {31'h0, exp});
	endtask
	// poll the commanded store subindex for its completion value
	task automatic save_wait(logic [7:0] s);
		logic [31:0] q;
		logic e;
		q = 32'h0;
		for (int n = 0; n < 40 && q !== SAVE_DONE_VAL; n++)
			u_apb_master.xfer(1'b0, oa(OBJ_STORE, s), 32'h0, q, e);
		check("store done", q, SAVE_DONE_VAL);
		pin("save_busy", 1'b0);
	endtask
	task automatic reboot();
		wr(oa(OBJ_REBOOT, SUB_BOOT), SIG_BOOT, 1'b0);
		repeat (3) @(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] q;
		logic e;
		pin("irq", 1'b0);
		pin("pready", 1'b1);
		rd(oa(OBJ_STORE, 8'h01), REG_RESET, "store01");
		rd(oa(OBJ_MARKER, SUB_DATE), MARKER_CLEAR, "marker");
		u_apb_master.xfer(1'b0, oa(16'h1234, 8'h00), 32'h0, q, e);
		check("unmapped err", {31'h0, e}, 32'h1);
		$display("test reset done");
	endtask
	// motor assumed still: this block has no motion interface
	task automatic t_save_all();
		for (int i = 0; i < 6; i++)
			wr(oa(OBJ_PARAM, 8'(i)), pv(i), 1'b0);
		wr(oa(OBJ_MARKER, SUB_DATE), dv, 1'b0);
		wr(oa(OBJ_MARKER, SUB_TIME), tv, 1'b0);
		wr(oa(OBJ_IRQ, SUB_MASK), 32'h7, 1'b0);
		wr(oa(OBJ_STORE, 8'h01), SIG_SAVE, 1'b0);
		pin("save_busy", 1'b1);
		wr(oa(OBJ_RESTORE, 8'h02), SIG_LOAD, 1'b1);
		save_wait(8'h01);
		pin("irq", 1'b1);
		rd(oa(OBJ_IRQ, SUB_STATUS), 32'h1, "status");
		wr(oa(OBJ_IRQ, SUB_STATUS), 32'h1, 1'b0);
		pin("irq", 1'b0);
		rd(oa(OBJ_MARKER, SUB_DATE), dv, "marker date");
		$display("test save all done");
	endtask
	task automatic t_marker_reboot();
		wr(oa(OBJ_STORE, 8'h02), 32'h12345678, 1'b0);
		pin("save_busy", 1'b0);
		rd(oa(OBJ_STORE, 8'h02), 32'h12345678, "store02");
		rd(oa(OBJ_MARKER, SUB_DATE), MARKER_CLEAR, "marker");
		wr(oa(OBJ_PARAM, 8'h00), 32'hdeadbeef, 1'b0);
		rd(oa(OBJ_PARAM, 8'h00), 32'hdeadbeef, "param0");
		reboot();
		for (int i = 0; i < 5; i++)
			rd(oa(OBJ_PARAM, 8'(i)), pv(i), "param");
		rd(oa(OBJ_PARAM, 8'h05), FACTORY_VALUE, "eth");
		rd(oa(OBJ_MARKER, SUB_DATE), dv, "date");
		rd(oa(OBJ_MARKER, SUB_TIME), tv, "time");
		rd(oa(OBJ_IRQ, SUB_STATUS), 32'h4, "status");
		wr(oa(OBJ_IRQ, SUB_STATUS), 32'h4, 1'b0);
		$display("test marker reboot done");
	endtask
	task automatic t_discard();
		wr(oa(OBJ_PARAM, 8'h05), pv(5), 1'b0);
		wr(oa(OBJ_STORE, 8'h0c), SIG_SAVE, 1'b0);
		save_wait(8'h0c);
		wr(oa(OBJ_IRQ, SUB_STATUS), 32'h1, 1'b0);
		wr(oa(OBJ_RESTORE, 8'h01), 32'h0bad0bad, 1'b0);
		rd(oa(OBJ_IRQ, SUB_STATUS), 32'h0, "status");
		wr(oa(OBJ_RESTORE, 8'h01), SIG_LOAD, 1'b0);
		rd(oa(OBJ_IRQ, SUB_STATUS), 32'h2, "status");
		rd(oa(OBJ_PARAM, 8'h00), pv(0), "param0");
		wr(oa(OBJ_REBOOT, SUB_BOOT), 32'h1, 1'b0);
		rd(oa(OBJ_PARAM, 8'h00), pv(0), "param0");
		reboot();
		for (int i = 0; i < 4; i++)
			rd(oa(OBJ_PARAM, 8'(i)), FACTORY_VALUE, "param");
		rd(oa(OBJ_PARAM, 8'h04), pv(4), "tuning");
		rd(oa(OBJ_PARAM, 8'h05), pv(5), "eth");
		wr(oa(OBJ_RESTORE, 8'h06), SIG_LOAD, 1'b0);
		reboot();
		rd(oa(OBJ_PARAM, 8'h04), FACTORY_VALUE, "tuning");
		rd(oa(OBJ_PARAM, 8'h05), pv(5), "eth");
		$display("test discard done");
	endtask

	// ----------------------------------------------------------------
	// verdict
	// ----------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		fail_count = 0;
		total_checks = 0;
		cycles = 0;
		dv = 32'h20250611;
		tv = 32'h00134500;
		nrst = 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_save_all();
		t_marker_reboot();
		t_discard();
		results();
	end
endmodule // param_store_tb_top
`default_nettype wire
